// ### inc/ssp_pkg.sv
// shared constants, encodings and carrier types of the serial command port
package ssp_pkg;

	// frame layout
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] CNT_FULL = 5'h10;
	localparam logic [4:0] CNT_SAT = 5'h1f;
	localparam logic [4:0] CNT_ADDR_DONE = 5'h07;
	localparam int ADDR_HI = 6;
	localparam int ACCESS_BIT = 7;
	localparam int DATA_LO = 8;
	localparam int DATA_HI = 15;
	localparam int STATUS_SEL_BIT = 6;
	localparam logic [15:0] FRAME_ZEROS = 16'h0000;
	localparam logic [15:0] FRAME_ONES = 16'hffff;

	// register addresses the port checks against
	localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
	localparam logic [6:0] ADDR_WATCHDOG_CONTROL_REG = 7'h02;
	localparam logic [6:0] ADDR_TRX_CTRL = 7'h04;
	localparam logic [6:0] ADDR_WAKE_EN = 7'h06;
	localparam logic [6:0] ADDR_TIMER1 = 7'h0c;
	localparam logic [6:0] ADDR_TIMER2 = 7'h0d;
	localparam logic [6:0] ADDR_PIN_CFG = 7'h17;
	localparam logic [6:0] ADDR_DEV_STAT = 7'h43;

	// field positions
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int MEAS_BIT = 5;
	localparam int TMR_PER_HI = 2;
	localparam int TMR_PER_LO = 0;
	localparam int TMR_ON_HI = 6;
	localparam int TMR_ON_LO = 4;
	localparam int SUM_WAKE_BIT = 4;

	// mode field values written to the mode control register
	localparam logic [1:0] MF_NORMAL = 2'h0;
	localparam logic [1:0] MF_SLEEP = 2'h1;
	localparam logic [1:0] MF_STOP = 2'h2;
	localparam logic [1:0] MF_SOFT_RST = 2'h3;

	// operating mode codes of the chip
	localparam logic [2:0] SBC_INIT = 3'h0;
	localparam logic [2:0] SBC_NORMAL = 3'h1;
	localparam logic [2:0] SBC_STOP = 3'h2;
	localparam logic [2:0] SBC_SLEEP = 3'h3;
	localparam logic [2:0] SBC_RESTART = 3'h4;
	localparam logic [2:0] SBC_FAILSAFE = 3'h5;

	// buffering
	localparam int FIFO_DEPTH = 32;

	typedef struct packed {
		logic mode_only;
		logic access;
		logic [6:0] addr;
		logic [7:0] data;
	} ssp_cmd_type;

	localparam int CMD_W = $bits(ssp_cmd_type);

	typedef enum logic [1:0] {PH_IDLE, PH_FRAME, PH_EXEC} ssp_phase_type;

	typedef struct packed {
		logic csn_m;
		logic csn_s;
		logic csn_p;
		logic clk_m;
		logic clk_s;
		logic clk_p;
		logic sdi_m;
		logic sdi_s;
		logic rst_m;
		logic rst_s;
		ssp_phase_type phase;
		logic [4:0] fall_cnt;
		logic [4:0] rise_cnt;
		logic [15:0] rx;
		logic [15:0] resp;
		logic sdo;
		logic drive;
		logic rst_seen;
		logic edge_bad;
		logic err;
		logic fail;
		logic [6:0] rd_addr;
		logic rd_cap;
		ssp_cmd_type cmd;
		logic push;
		logic mreq_v;
		logic [2:0] mreq_t;
		logic irq;
	} ssp_state_type;

	localparam ssp_state_type STATE_RESET = '{
		csn_m: 1'b1, csn_s: 1'b1, csn_p: 1'b1,
		clk_m: 1'b0, clk_s: 1'b0, clk_p: 1'b0,
		sdi_m: 1'b0, sdi_s: 1'b0, rst_m: 1'b0, rst_s: 1'b0,
		phase: PH_IDLE, fall_cnt: 5'h00, rise_cnt: 5'h00,
		rx: 16'h0000, resp: 16'h0000, sdo: 1'b1, drive: 1'b0,
		rst_seen: 1'b0, edge_bad: 1'b0, err: 1'b0, fail: 1'b0,
		rd_addr: 7'h00, rd_cap: 1'b0, cmd: '0, push: 1'b0,
		mreq_v: 1'b0, mreq_t: 3'h0, irq: 1'b0};

endpackage

// ### verilog/ssp_command_port.sv
// command fifo and serial command port of the system basis chip

// command fifo: valid/ready on both sides, honest full and empty
module ssp_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 32
) (
	// clock, reset and enable
	input wire logic clock,
	input wire logic resetn,
	input wire logic clk_en,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} ssp_fifo_state_type;

	ssp_fifo_state_type s_r;
	ssp_fifo_state_type s_nxt;
	logic [WIDTH-1:0] mem [DEPTH];
	logic do_wr;
	logic do_rd;

	assign in_ready = (s_r.count != (AW+1)'(DEPTH));
	assign out_valid = (s_r.count != '0);
	assign out_data = mem[s_r.rd_ptr];
	assign do_wr = in_valid && in_ready && clk_en;
	assign do_rd = out_valid && out_ready && clk_en;

	// pointer and occupancy update; pointers wrap only for power-of-two depth
	always_comb begin
		s_nxt = s_r;
		if (do_wr) begin
			s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
		end
		if (do_rd) begin
			s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
		end
		if (do_wr && !do_rd) begin
			s_nxt.count = s_r.count + 1'b1;
		end else if (do_rd && !do_wr) begin
			s_nxt.count = s_r.count - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// storage array, no reset needed since empty slots are never read out
	always_ff @(posedge clock) begin
		if (do_wr) begin
			mem[s_r.wr_ptr] <= in_data;
		end
	end
endmodule

module ssp_command_port (
	// clock, reset, enable
	input wire logic clock,
	input wire logic resetn,
	input wire logic clk_en,
	// serial pins
	input wire logic chip_select_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo_out,
	output logic sdo_oe_n,
	// chip state seen by the port
	input wire logic reset_out_n,
	input wire logic [2:0] sbc_mode,
	input wire logic fail_output,
	input wire logic [7:0] transceiver_ctrl_reg,
	input wire logic [7:0] wake_enable_reg,
	input wire logic [7:0] pin_config_reg,
	input wire logic [7:0] wake_status_low_reg,
	input wire logic [7:0] wake_status_high_reg,
	input wire logic [7:0][7:0] status_regs,
	// same-frame read port
	output logic [6:0] rd_addr,
	input wire logic [7:0] rd_data,
	// accepted commands toward the register file
	output logic cmd_valid,
	input wire logic cmd_ready,
	output ssp_pkg::ssp_cmd_type cmd_data,
	// flags and requests
	output logic frame_err,
	output logic spi_fail,
	output logic mode_req_valid,
	output logic [2:0] mode_req_target,
	output logic irq_out_n
);
	ssp_pkg::ssp_state_type s_r;
	ssp_pkg::ssp_state_type s_nxt;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [ssp_pkg::CMD_W-1:0] fifo_out_data;
	logic [7:0] summary;
	logic wake_any;

	assign wake_any = (wake_status_low_reg != 8'h00) || (wake_status_high_reg != 8'h00);

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_sum
			if (gi == ssp_pkg::SUM_WAKE_BIT) begin : g_wake
				assign summary[gi] = wake_any;
			end else begin : g_reg
				assign summary[gi] = (status_regs[gi] != 8'h00);
			end
		end
	endgenerate

	// frame tracking, shifting and command decode
	always_comb begin
		logic csn_fall;
		logic csn_rise;
		logic clk_rise;
		logic clk_fall;
		logic enabled;
		logic fault;
		logic [6:0] addr;
		logic acc;
		logic [7:0] d;
		logic [1:0] mf;
		logic rej;
		logic keep;
		logic clr_fail;
		s_nxt = s_r;
		csn_fall = s_r.csn_p && !s_r.csn_s;
		csn_rise = !s_r.csn_p && s_r.csn_s;
		clk_rise = s_r.clk_s && !s_r.clk_p;
		clk_fall = !s_r.clk_s && s_r.clk_p;
		// port live in init, normal, stop
		enabled = (sbc_mode == ssp_pkg::SBC_INIT) || (sbc_mode == ssp_pkg::SBC_NORMAL)
			|| (sbc_mode == ssp_pkg::SBC_STOP);
		fault = 1'b0;
		addr = s_r.rx[ssp_pkg::ADDR_HI:0];
		acc = s_r.rx[ssp_pkg::ACCESS_BIT];
		d = s_r.rx[ssp_pkg::DATA_HI:ssp_pkg::DATA_LO];
		mf = d[ssp_pkg::MODE_HI:ssp_pkg::MODE_LO];
		rej = 1'b0;
		keep = 1'b0;
		clr_fail = 1'b0;
		// two-stage synchronisers, third stage only for edges
		s_nxt.csn_m = chip_select_n;
		s_nxt.csn_s = s_r.csn_m;
		s_nxt.csn_p = s_r.csn_s;
		s_nxt.clk_m = sclk;
		s_nxt.clk_s = s_r.clk_m;
		s_nxt.clk_p = s_r.clk_s;
		s_nxt.sdi_m = sdi;
		s_nxt.sdi_s = s_r.sdi_m;
		s_nxt.rst_m = reset_out_n;
		s_nxt.rst_s = s_r.rst_m;
		s_nxt.mreq_v = 1'b0;
		s_nxt.irq = 1'b0;
		s_nxt.rd_cap = 1'b0;
		// same-frame read data lands in the upper response byte
		if (s_r.rd_cap) begin
			s_nxt.resp[ssp_pkg::DATA_HI:ssp_pkg::DATA_LO] = rd_data;
		end
		case (s_r.phase)
			ssp_pkg::PH_IDLE: begin
				if (csn_fall) begin
					s_nxt.phase = ssp_pkg::PH_FRAME;
					s_nxt.fall_cnt = 5'h00;
					s_nxt.rise_cnt = 5'h00;
					s_nxt.rx = 16'h0000;
					s_nxt.resp = {8'h00, summary};
					s_nxt.sdo = s_r.err;
					s_nxt.err = 1'b0;
					s_nxt.drive = enabled || !s_r.rst_s;
					s_nxt.edge_bad = s_r.clk_s;
					s_nxt.rst_seen = !s_r.rst_s;
				end
			end
			ssp_pkg::PH_FRAME: begin
				// remember reset low anywhere in frame
				if (!s_r.rst_s) begin
					s_nxt.rst_seen = 1'b1;
				end
				// next response bit after rising clock
				if (clk_rise) begin
					if (s_r.rise_cnt < ssp_pkg::CNT_FULL) begin
						s_nxt.sdo = s_r.resp[s_r.rise_cnt[3:0]];
					end
					if (s_r.rise_cnt != ssp_pkg::CNT_SAT) begin
						s_nxt.rise_cnt = s_r.rise_cnt + 5'h01;
					end
				end
				// capture input bit on falling clock
				if (clk_fall) begin
					if (s_r.fall_cnt < ssp_pkg::CNT_FULL) begin
						s_nxt.rx[s_r.fall_cnt[3:0]] = s_r.sdi_s;
					end
					if (s_r.fall_cnt != ssp_pkg::CNT_SAT) begin
						s_nxt.fall_cnt = s_r.fall_cnt + 5'h01;
					end
					// status address known, fetch for this frame
					if (s_r.fall_cnt == ssp_pkg::CNT_ADDR_DONE) begin
						s_nxt.rd_addr = s_r.rx[ssp_pkg::ADDR_HI:0];
						s_nxt.rd_cap = 1'b1;
					end
				end
				// interpret on select release and free the line
				if (csn_rise) begin
					s_nxt.drive = 1'b0;
					s_nxt.sdo = 1'b1;
					s_nxt.phase = ssp_pkg::PH_IDLE;
					// clock count and clock level at select edges
					fault = ((s_r.fall_cnt != 5'h00) && (s_r.fall_cnt != ssp_pkg::CNT_FULL))
						|| s_r.edge_bad || s_r.clk_s;
					// frame start, end or body in reset
					fault = fault || s_r.rst_seen || !s_r.rst_s;
					if (fault) begin
						s_nxt.err = 1'b1;
					end else if ((s_r.fall_cnt == 5'h00) || !enabled) begin
						keep = 1'b0;
					end else if ((s_r.rx == ssp_pkg::FRAME_ZEROS) || (s_r.rx == ssp_pkg::FRAME_ONES)) begin
						rej = 1'b1;
					end else if (addr[ssp_pkg::STATUS_SEL_BIT]) begin
						keep = acc;
						clr_fail = acc && (addr == ssp_pkg::ADDR_DEV_STAT);
					end else if (acc) begin
						keep = 1'b1;
						// odd watchdog parity drops trigger and settings
						if ((addr == ssp_pkg::ADDR_WATCHDOG_CONTROL_REG) && (^d)) begin
							rej = 1'b1;
						end else if (sbc_mode == ssp_pkg::SBC_STOP) begin
							if (addr == ssp_pkg::ADDR_MODE_CTRL) begin
								case (mf)
									ssp_pkg::MF_NORMAL: begin
										// only the mode change is kept
										s_nxt.cmd.mode_only = 1'b1;
										s_nxt.mreq_v = 1'b1;
										s_nxt.mreq_t = ssp_pkg::SBC_NORMAL;
									end
									ssp_pkg::MF_SOFT_RST: begin
										s_nxt.mreq_v = 1'b1;
										s_nxt.mreq_t = ssp_pkg::SBC_RESTART;
									end
									ssp_pkg::MF_SLEEP: begin
										rej = 1'b1;
										s_nxt.mreq_v = 1'b1;
										s_nxt.mreq_t = ssp_pkg::SBC_RESTART;
									end
									default: begin
										rej = 1'b1;
									end
								endcase
							end else if (addr != ssp_pkg::ADDR_WATCHDOG_CONTROL_REG) begin
								// no other change allowed in stop
								rej = 1'b1;
							end
						end else if (addr == ssp_pkg::ADDR_MODE_CTRL) begin
							s_nxt.mreq_v = 1'b1;
							case (mf)
								ssp_pkg::MF_NORMAL: s_nxt.mreq_t = ssp_pkg::SBC_NORMAL;
								ssp_pkg::MF_SOFT_RST: s_nxt.mreq_t = ssp_pkg::SBC_RESTART;
								default: s_nxt.mreq_t = (mf == ssp_pkg::MF_STOP) ?
									ssp_pkg::SBC_STOP : ssp_pkg::SBC_SLEEP;
							endcase
							if ((sbc_mode == ssp_pkg::SBC_INIT) && (mf != ssp_pkg::MF_NORMAL)
								&& (mf != ssp_pkg::MF_SOFT_RST)) begin
								// init refuses low power, goes normal
								rej = 1'b1;
								s_nxt.mreq_t = ssp_pkg::SBC_NORMAL;
							end else if ((mf == ssp_pkg::MF_SLEEP)
								&& (transceiver_ctrl_reg == 8'h00) && (wake_enable_reg == 8'h00)
								&& (pin_config_reg == 8'h00)) begin
								// no wake source: restart, rest still applied
								s_nxt.fail = 1'b1;
								s_nxt.mreq_t = ssp_pkg::SBC_RESTART;
							end else if ((mf == ssp_pkg::MF_STOP) && wake_any) begin
								s_nxt.irq = 1'b1;
							end
						end else if ((addr == ssp_pkg::ADDR_WAKE_EN) && d[ssp_pkg::MEAS_BIT]
							&& (fail_output || (pin_config_reg != 8'h00))) begin
							// measurement needs pin and fail output off
							rej = 1'b1;
						end else if ((addr == ssp_pkg::ADDR_PIN_CFG)
							&& wake_enable_reg[ssp_pkg::MEAS_BIT]) begin
							rej = 1'b1;
						end else if (((addr == ssp_pkg::ADDR_TIMER1) || (addr == ssp_pkg::ADDR_TIMER2))
							&& (d[ssp_pkg::TMR_ON_HI:ssp_pkg::TMR_ON_LO]
							>= d[ssp_pkg::TMR_PER_HI:ssp_pkg::TMR_PER_LO])) begin
							// on-time must be shorter than period
							rej = 1'b1;
						end
					end
					if (rej) begin
						keep = 1'b0;
						s_nxt.mreq_v = s_nxt.mreq_v && (s_nxt.mreq_t != ssp_pkg::SBC_STOP);
					end
					if (!s_nxt.cmd.mode_only || !keep) begin
						s_nxt.cmd.mode_only = 1'b0;
					end
					s_nxt.cmd.access = acc;
					s_nxt.cmd.addr = addr;
					s_nxt.cmd.data = d;
					s_nxt.push = keep;
					if (keep) begin
						s_nxt.phase = ssp_pkg::PH_EXEC;
					end
				end
			end
			ssp_pkg::PH_EXEC: begin
				// wait here while the fifo is full; this back-pressures the frame path
				if (fifo_in_ready) begin
					s_nxt.push = 1'b0;
					s_nxt.cmd.mode_only = 1'b0;
					s_nxt.phase = ssp_pkg::PH_IDLE;
				end
			end
			default: begin
				s_nxt.phase = ssp_pkg::PH_IDLE;
			end
		endcase
		// set wins over the host clear
		s_nxt.fail = (s_nxt.fail && !clr_fail) || rej;
		// output high in reset, and whenever released
		if (!s_r.rst_s || !s_nxt.drive) begin
			s_nxt.sdo = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_r <= ssp_pkg::STATE_RESET;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	ssp_fifo #(
		.WIDTH(ssp_pkg::CMD_W),
		.DEPTH(ssp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.clk_en(clk_en),
		.in_valid(s_r.push && (s_r.phase == ssp_pkg::PH_EXEC)),
		.in_ready(fifo_in_ready),
		.in_data(s_r.cmd),
		.out_valid(fifo_out_valid),
		.out_ready(cmd_ready),
		.out_data(fifo_out_data)
	);

	// outputs straight from state
	assign sdo_out = s_r.sdo;
	assign sdo_oe_n = !s_r.drive; // low while the port owns the line
	assign rd_addr = s_r.rd_addr;
	assign cmd_valid = fifo_out_valid;
	assign cmd_data = ssp_pkg::ssp_cmd_type'(fifo_out_data);
	assign frame_err = s_r.err;
	assign spi_fail = s_r.fail;
	assign mode_req_valid = s_r.mreq_v;
	assign mode_req_target = s_r.mreq_t;
	assign irq_out_n = !s_r.irq;
endmodule

// ### verif/ssp_command_port_chk.sv
// concurrent checks on the ports of the serial command port
module ssp_command_port_chk (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// serial pins
	input wire logic chip_select_n,
	input wire logic sclk,
	input wire logic sdo_out,
	input wire logic sdo_oe_n,
	// chip state
	input wire logic reset_out_n,
	input wire logic [2:0] sbc_mode,
	input wire logic [7:0] wake_status_low_reg,
	input wire logic [7:0] wake_status_high_reg,
	// flags and requests
	input wire logic frame_err,
	input wire logic spi_fail,
	input wire logic mode_req_valid,
	input wire logic [2:0] mode_req_target,
	input wire logic irq_out_n
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// the pins pass two sync stages, so answers lag the pins by a few cycles
	release_out_a: assert property ($rose(chip_select_n) |-> ##[1:6] sdo_oe_n)
		else $error("output not released after select rise");
	idle_high_a: assert property (sdo_oe_n |-> sdo_out)
		else $error("released output not high");
	reset_high_a: assert property (!reset_out_n [*4] |-> sdo_out)
		else $error("output not high while chip reset is low");
	advance_rise_a: assert property (!sdo_oe_n && !$past(sdo_oe_n) && $changed(sdo_out)
		|-> $past(sclk, 2) || $past(sclk, 3) || $past(sclk, 4) || $past(sclk, 5))
		else $error("output bit changed away from a rising serial clock");
	drive_mode_a: assert property ($fell(sdo_oe_n) && reset_out_n && $past(reset_out_n, 4)
		|-> sbc_mode <= ssp_pkg::SBC_STOP)
		else $error("output driven in a mode with the port disabled");
	flag_release_a: assert property ($changed(spi_fail) || $rose(frame_err)
		|-> chip_select_n && !$past(chip_select_n, 8))
		else $error("flag changed away from a select release");
	err_clear_a: assert property ($fell(frame_err) |-> !chip_select_n)
		else $error("frame fault cleared without a new frame");
	mreq_pulse_a: assert property (mode_req_valid |-> chip_select_n && !$past(chip_select_n, 8)
		&& mode_req_target != ssp_pkg::SBC_INIT ##1 !mode_req_valid)
		else $error("bad mode request pulse");
	irq_wake_a: assert property ($fell(irq_out_n) |-> !$rose(spi_fail)
		&& (wake_status_low_reg != 8'h00 || wake_status_high_reg != 8'h00) ##1 irq_out_n)
		else $error("interrupt pulse without wake status");
endmodule

bind ssp_command_port ssp_command_port_chk ssp_command_port_chk_i (.clock, .resetn,
	.chip_select_n, .sclk, .sdo_out, .sdo_oe_n, .reset_out_n, .sbc_mode, .wake_status_low_reg,
	.wake_status_high_reg, .frame_err, .spi_fail, .mode_req_valid, .mode_req_target, .irq_out_n);

// ### verif/ssp_host_model.sv
// host side model: drives select, serial clock and data, captures the answer
module ssp_host_model (
	// serial pins
	output logic chip_select_n,
	output logic sclk,
	output logic sdi,
	input wire logic sdo_out,
	input wire logic sdo_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic drove;

	// note whether the device drove the line during a frame
	always @(negedge sdo_oe_n) drove = 1'b1;
	initial begin
		chip_select_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end

	task automatic xfer(input logic [15:0] tx, input int nclk, output logic [15:0] rx,
		output logic err, output logic oe);
		int k;
		#1.3ns;
		drove = 1'b0;
		chip_select_n = 1'b0;
		#64ns;
		err = sdo_out;
		rx = 16'h0000;
		// data changes at the rise, the device takes it at the fall
		for (k = 0; k < nclk; k++) begin
			sclk = 1'b1;
			sdi = tx[k % 16];
			#32ns;
			rx[k % 16] = sdo_out;
			sclk = 1'b0;
			#32ns;
		end
		#32ns;
		chip_select_n = 1'b1;
		oe = drove;
		// a released data line must not keep showing the last bit
		sdi = ~sdi;
		#64ns;
	endtask
endmodule

// ### verif/ssp_command_port_tb.sv
// self-checking bench of the serial command port with a host model
module ssp_command_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, resetn, clk_en, chip_select_n, sclk, sdi, sdo_out, sdo_oe_n;
	logic reset_out_n, fail_output, cmd_valid, cmd_ready, frame_err, spi_fail;
	logic mode_req_valid, irq_out_n, err, oe;
	logic [2:0] sbc_mode, mode_req_target, last_tgt;
	logic [7:0] trx, wake_en, pin_cfg, wk_lo, wk_hi, rd_data;
	logic [7:0][7:0] status_regs;
	logic [6:0] rd_addr;
	logic [15:0] rx;
	ssp_pkg::ssp_cmd_type cmd_data, last_cmd;
	int n_errors = 0, checks = 0, n_push = 0, n_mreq = 0, n_irq = 0, cycles = 0, i0, i1;

	ssp_command_port ssp_command_port_i (.clock, .resetn, .clk_en, .chip_select_n, .sclk,
		.sdi, .sdo_out, .sdo_oe_n, .reset_out_n, .sbc_mode, .fail_output,
		.transceiver_ctrl_reg(trx), .wake_enable_reg(wake_en), .pin_config_reg(pin_cfg),
		.wake_status_low_reg(wk_lo), .wake_status_high_reg(wk_hi), .status_regs, .rd_addr,
		.rd_data, .cmd_valid, .cmd_ready, .cmd_data, .frame_err, .spi_fail, .mode_req_valid,
		.mode_req_target, .irq_out_n);
	ssp_host_model ssp_host_model_i (.chip_select_n, .sclk, .sdi, .sdo_out, .sdo_oe_n);
	// register file stand-in answering the same-frame read
	assign rd_data = {1'b0, rd_addr} ^ 8'ha5;

	// free running system clock
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// count handshakes, pulses and cycles; a hang ends the run
	always @(posedge clock) begin
		cycles++;
		if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
			n_push++;
			last_cmd = cmd_data;
		end
		if (mode_req_valid === 1'b1) begin
			n_mreq++;
			last_tgt = mode_req_target;
		end
		if (irq_out_n === 1'b0) n_irq++;
		if (cycles == 60000) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t ns: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// one frame of n clocks, then let the decode settle
	task automatic frame(input logic [15:0] tx, input int n);
		ssp_host_model_i.xfer(tx, n, rx, err, oe);
		repeat (20) @(negedge clock);
	endtask
	// one command in a mode; expected flag, pushes and {request, target}
	task automatic cmd(input logic [2:0] mode, input logic [6:0] addr, input logic [7:0] data,
		input logic efail, input int epush, input logic [3:0] ereq);
		int p0, m0;
		@(negedge clock);
		sbc_mode = mode;
		p0 = n_push;
		m0 = n_mreq;
		frame({data, 1'b1, addr}, 16);
		check(spi_fail, efail, "rejection flag");
		check(n_push - p0, epush, "pushes");
		check((n_mreq != m0) ? {1'b1, last_tgt} : 4'h0, ereq, "mode request");
		// read-and-clear of the device status clears the sticky flag
		if (spi_fail === 1'b1) begin
			frame({8'h00, 1'b1, ssp_pkg::ADDR_DEV_STAT}, 16);
			check(spi_fail, 1'b0, "flag clear");
		end
	endtask

	initial begin
		clk_en = 1'b1;
		resetn = 1'b0;
		cmd_ready = 1'b1;
		reset_out_n = 1'b1;
		fail_output = 1'b0;
		sbc_mode = ssp_pkg::SBC_NORMAL;
		trx = 8'h01;
		wake_en = 8'h00;
		pin_cfg = 8'h00;
		wk_lo = 8'h00;
		wk_hi = 8'h00;
		status_regs = '0;
		status_regs[0] = 8'h10;
		status_regs[7] = 8'h02;
		repeat (8) @(negedge clock);
		resetn = 1'b1;
		repeat (8) @(negedge clock);
		frame(16'h0000, 0);
		check(err, 1'b0, "clean fault bit");
		// miscounted frames are dropped and flagged at release; the next select fall shows the fault bit and clears the flag
		for (int j = 0; j < 2; j++) begin
			frame(16'h5a84, j ? 17 : 8);
			check(frame_err, 1'b1, "fault flag");
			frame(16'h0000, 0);
			check(err, 1'b1, "fault bit shown");
			check(frame_err, 1'b0, "fault cleared");
		end
		// serial clock high at the select edges spoils the frame
		ssp_host_model_i.sclk = 1'b1;
		frame(16'h0000, 0);
		ssp_host_model_i.sclk = 1'b0;
		check(frame_err, 1'b1, "clock high at select");
		check(n_push, 0, "dropped frames");
		// same-frame read: summary then data, read-only is not pushed
		frame({8'h00, 1'b0, ssp_pkg::ADDR_DEV_STAT}, 16);
		check(rx, 16'he681, "read answer");
		check(n_push, 0, "read-only push");
		cmd(ssp_pkg::SBC_NORMAL, ssp_pkg::ADDR_TRX_CTRL, 8'h3c, 0, 1, 4'h0);
		check({last_cmd.access, last_cmd.addr, last_cmd.data}, 16'h843c, "fields");
		// an all-zero frame carries a clear access bit, so it bypasses the command task
		i0 = n_push;
		i1 = n_mreq;
		frame(16'h0000, 16);
		check(spi_fail, 1'b1, "stuck low flag");
		check(n_push - i0, 0, "stuck low push");
		check(n_mreq - i1, 0, "stuck low request");
		frame({8'h00, 1'b1, ssp_pkg::ADDR_DEV_STAT}, 16);
		check(spi_fail, 1'b0, "stuck low clear");
		cmd(ssp_pkg::SBC_NORMAL, 7'h7f, 8'hff, 1, 0, 4'h0);
		cmd(ssp_pkg::SBC_INIT, ssp_pkg::ADDR_MODE_CTRL, 8'h80, 1, 0, 4'h9);
		cmd(ssp_pkg::SBC_INIT, ssp_pkg::ADDR_MODE_CTRL, 8'h40, 1, 0, 4'h9);
		cmd(ssp_pkg::SBC_STOP, ssp_pkg::ADDR_MODE_CTRL, 8'h40, 1, 0, 4'hc);
		cmd(ssp_pkg::SBC_STOP, ssp_pkg::ADDR_TRX_CTRL, 8'h01, 1, 0, 4'h0);
		cmd(ssp_pkg::SBC_STOP, ssp_pkg::ADDR_MODE_CTRL, 8'h15, 0, 1, 4'h9);
		check(last_cmd.mode_only, 1'b1, "mode only");
		cmd(ssp_pkg::SBC_STOP, ssp_pkg::ADDR_MODE_CTRL, 8'hc0, 0, 1, 4'hc);
		cmd(ssp_pkg::SBC_STOP, ssp_pkg::ADDR_WATCHDOG_CONTROL_REG, 8'h03, 0, 1, 4'h0);
		cmd(ssp_pkg::SBC_NORMAL, ssp_pkg::ADDR_WATCHDOG_CONTROL_REG, 8'h01, 1, 0, 4'h0);
		cmd(ssp_pkg::SBC_NORMAL, ssp_pkg::ADDR_TIMER1, 8'h33, 1, 0, 4'h0);
		cmd(ssp_pkg::SBC_NORMAL, ssp_pkg::ADDR_TIMER2, 8'h43, 1, 0, 4'h0);
		cmd(ssp_pkg::SBC_NORMAL, ssp_pkg::ADDR_TIMER2, 8'h34, 0, 1, 4'h0);
		fail_output = 1'b1;
		cmd(ssp_pkg::SBC_NORMAL, ssp_pkg::ADDR_WAKE_EN, 8'h20, 1, 0, 4'h0);
		fail_output = 1'b0;
		wake_en = 8'h20;
		cmd(ssp_pkg::SBC_NORMAL, ssp_pkg::ADDR_PIN_CFG, 8'h01, 1, 0, 4'h0);
		wake_en = 8'h00;
		trx = 8'h00;
		cmd(ssp_pkg::SBC_NORMAL, ssp_pkg::ADDR_MODE_CTRL, 8'h40, 1, 1, 4'hc);
		trx = 8'h01;
		cmd(ssp_pkg::SBC_NORMAL, ssp_pkg::ADDR_MODE_CTRL, 8'h40, 0, 1, 4'hb);
		wk_lo = 8'h02;
		i0 = n_irq;
		cmd(ssp_pkg::SBC_NORMAL, ssp_pkg::ADDR_MODE_CTRL, 8'h80, 0, 1, 4'ha);
		check(n_irq - i0, 1, "wake interrupt");
		wk_lo = 8'h00;
		// disabled modes neither interpret nor drive the line
		for (int m = ssp_pkg::SBC_SLEEP; m <= ssp_pkg::SBC_FAILSAFE; m++) begin
			cmd(3'(m), ssp_pkg::ADDR_TRX_CTRL, 8'h01, 0, 0, 4'h0);
			check(oe, 1'b0, "driven while disabled");
		end
		// a frame wholly inside chip reset answers all ones and is flagged
		sbc_mode = ssp_pkg::SBC_NORMAL;
		reset_out_n = 1'b0;
		repeat (4) @(negedge clock);
		frame(16'h1284, 16);
		check(rx, 16'hffff, "output in reset");
		reset_out_n = 1'b1;
		repeat (8) @(negedge clock);
		check(frame_err, 1'b1, "reset overlap");
		frame(16'h0000, 0);
		check(err, 1'b1, "reset overlap shown");
		// stalled drain: 32 stored plus one waiting, then drained in order
		cmd_ready = 1'b0;
		for (int k = 0; k < 33; k++) frame({8'(k), 1'b1, ssp_pkg::ADDR_TRX_CTRL}, 16);
		for (int k = 0; k < 33; k++) begin
			check({cmd_valid, cmd_data.data}, {1'b1, 8'(k)}, "fifo order");
			cmd_ready = 1'b1;
			@(negedge clock);
			cmd_ready = 1'b0;
			repeat (2) @(negedge clock);
		end
		check(cmd_valid, 1'b0, "fifo empty");
		print_verdict();
	end
endmodule
